// ==== logic/dual_uart.sv ====
// Two serial ports behind one classic Wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "dual_uart_defines.svh"
// What this block does
// - Two identical ports each decode the same offsets at their own base.
// - With divisor access clear, a read at 0x00 returns the received byte.
// - With divisor access clear, a write at 0x00 loads the transmit byte.
// - With divisor access set, 0x00 and 0x04 reach the divisor bytes.
// - Characters go out and come in least significant bit first.
// - In legacy mode the FIFO bits of identification and status read 0.
// - A divisor byte write reloads the 16x baud counter at once.
module dual_uart
    import dual_uart_pkg::*;
#(
    parameter logic [7:0] FIRST_PORT_BASE = `FIRST_PORT_BASE,
    parameter logic [7:0] SECOND_PORT_BASE = `SECOND_PORT_BASE
) (
    // System
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial lines and modem pins, index is the port
    input wire logic [1:0] serial_in_i,
    output logic [1:0] serial_out_o,
    input wire modem_in_type [1:0] modem_i,
    output modem_out_type [1:0] modem_o,
    // Interrupt
    output logic irq_o
);
    function automatic logic port_hit(input logic [7:0] adr,
                                      input logic [7:0] base);
        port_hit = (adr[7:6] == base[7:6]);
    endfunction

    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [7:0] lc);
        logic [7:0] m;
        m = d & (8'hFF >> ~lc[1:0]);
        if (lc[5]) begin
            par_bit = ~lc[4];
        end else begin
            par_bit = lc[4] ? ^m : ~^m;
        end
    endfunction

    logic req;
    logic [1:0] hit;
    logic [1:0] irq_port;
    wire [7:0] rd_val [2];

    // Side effects happen on the edge that raises ack, exactly once
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign irq_o = |irq_port;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && req) begin
            wb_dat_o <= {24'h00_0000, hit[0] ? rd_val[0] :
                         (hit[1] ? rd_val[1] : 8'h00)};
        end
    end

    for (genvar g = 0; g < 2; g++) begin : port
        localparam logic [7:0] BASE = (g == 0) ? FIRST_PORT_BASE :
                                                 SECOND_PORT_BASE;
        logic wr, rd, div_sel, loop, tick, tx_load, rx_in, tx_line;
        logic [3:0] ien, mctl_n, evt_stat, evt_en, modem_now, modem_prev;
        logic [3:0] delta, evt;
        logic [4:0] mctl;
        logic [7:0] lctl, scratch, rx_hold, tx_hold, tx_sh, rx_sh, rd_mux;
        logic [7:0] ident, lstat;
        logic [15:0] divisor, baud_cnt;
        logic fifo_en, hold_full, thre_int, dr, oe, pe, fe, bi;
        logic tx_par, rx_done, rx_pe, rx_fe, rx_bi, rx_par_bad;
        logic rx_hold_rd, lstat_rd;
        logic [2:0] tx_bit, rx_bit, iid;
        logic [5:0] tx_sub, rx_sub;
        logic [7:0] rx_data;
        tx_state_type tx_state;
        rx_state_type rx_state;

        assign hit[g] = port_hit(wb_adr_i, BASE);
        assign wr = req & hit[g] & wb_we_i & wb_sel_i[0];
        assign rd = req & hit[g] & ~wb_we_i;
        assign div_sel = lctl[`LCTL_DIV_SEL];
        assign loop = mctl[`MCTL_LOOP];
        assign rx_hold_rd = rd && !div_sel && wb_adr_i[5:0] == `OFS_DATA;
        assign lstat_rd = rd && wb_adr_i[5:0] == `OFS_LSTAT;

        // Loopback feeds the modem outputs back as inputs
        assign mctl_n = ~{mctl[3], mctl[2], mctl[0], mctl[1]};
        assign modem_now = loop ? ~mctl_n : ~modem_i[g];
        assign tx_line = (tx_state == TX_IDLE) ? 1'b1 :
                         (tx_state == TX_START) ? 1'b0 : tx_sh[0];
        assign rx_in = loop ? (tx_line & ~lctl[`LCTL_BREAK]) : serial_in_i[g];
        assign serial_out_o[g] = loop | (tx_line & ~lctl[`LCTL_BREAK]);
        assign modem_o[g].dtr_n = loop | ~mctl[0];
        assign modem_o[g].rts_n = loop | ~mctl[1];

        assign tick = (baud_cnt <= 16'h0001);
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                baud_cnt <= `DIV_RESET;
            end else if (ce_i) begin
                if (wr && div_sel && wb_adr_i[5:0] == `OFS_DATA) begin
                    baud_cnt <= {divisor[15:8], wb_dat_i[7:0]};
                end else if (wr && div_sel && wb_adr_i[5:0] == `OFS_IEN) begin
                    baud_cnt <= {wb_dat_i[7:0], divisor[7:0]};
                end else begin
                    baud_cnt <= tick ? divisor : baud_cnt - 16'h0001;
                end
            end
        end

        // Control registers written by software
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                ien <= 4'h0;
                lctl <= 8'h00;
                mctl <= 5'h00;
                scratch <= 8'h00;
                divisor <= `DIV_RESET;
                fifo_en <= 1'b0;
                evt_en <= 4'h0;
            end else if (ce_i && wr) begin
                case (wb_adr_i[5:0])
                    `OFS_DATA: if (div_sel) divisor[7:0] <= wb_dat_i[7:0];
                    `OFS_IEN: begin
                        if (div_sel) begin
                            divisor[15:8] <= wb_dat_i[7:0];
                        end else begin
                            ien <= wb_dat_i[3:0];
                        end
                    end
                    `OFS_IDENT: fifo_en <= wb_dat_i[0];
                    `OFS_LCTL: lctl <= wb_dat_i[7:0];
                    `OFS_MCTL: mctl <= wb_dat_i[4:0];
                    `OFS_SCRATCH: scratch <= wb_dat_i[7:0];
                    `OFS_EVT_EN: evt_en <= wb_dat_i[3:0];
                    default: ;
                endcase
            end
        end

        // Transmit holding register and its empty interrupt
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                tx_hold <= 8'h00;
                hold_full <= 1'b0;
                thre_int <= 1'b0;
            end else if (ce_i) begin
                if (wr && !div_sel && wb_adr_i[5:0] == `OFS_DATA) begin
                    tx_hold <= wb_dat_i[7:0];
                    hold_full <= 1'b1;
                    thre_int <= 1'b0;
                end else if (tx_load) begin
                    hold_full <= 1'b0;
                    thre_int <= 1'b1;
                end else if (rd && wb_adr_i[5:0] == `OFS_IDENT &&
                             iid == 3'b010) begin
                    thre_int <= 1'b0;
                end
            end
        end

        // Shifter copies the byte at load, so a refill cannot corrupt it
        assign tx_load = (tx_state == TX_IDLE) & hold_full;
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                tx_state <= TX_IDLE;
                tx_sh <= 8'hFF;
                tx_bit <= 3'd0;
                tx_sub <= 6'd0;
                tx_par <= 1'b0;
            end else if (ce_i) begin
                case (tx_state)
                    TX_IDLE: begin
                        if (hold_full) begin
                            tx_state <= TX_START;
                            tx_sh <= tx_hold;
                            tx_sub <= 6'd0;
                            tx_par <= par_bit(tx_hold, lctl);
                        end
                    end
                    TX_START: begin
                        if (tick) begin
                            tx_sub <= tx_sub + 6'd1;
                            if (tx_sub == `TICKS_BIT) begin
                                tx_state <= TX_DATA;
                                tx_bit <= 3'd0;
                                tx_sub <= 6'd0;
                            end
                        end
                    end
                    TX_DATA: begin
                        if (tick) begin
                            tx_sub <= tx_sub + 6'd1;
                            if (tx_sub == `TICKS_BIT) begin
                                tx_sub <= 6'd0;
                                tx_bit <= tx_bit + 3'd1;
                                tx_sh <= {1'b1, tx_sh[7:1]};
                                if (tx_bit == {1'b1, lctl[1:0]}) begin
                                    tx_state <= lctl[3] ? TX_PARITY : TX_STOP;
                                    tx_sh <= {7'h7F, ~lctl[3] | tx_par};
                                end
                            end
                        end
                    end
                    TX_PARITY: begin
                        if (tick) begin
                            tx_sub <= tx_sub + 6'd1;
                            if (tx_sub == `TICKS_BIT) begin
                                tx_state <= TX_STOP;
                                tx_sh <= 8'hFF;
                                tx_sub <= 6'd0;
                            end
                        end
                    end
                    TX_STOP: begin
                        if (tick) begin
                            tx_sub <= tx_sub + 6'd1;
                            if (tx_sub == (!lctl[2] ? `TICKS_STOP_ONE :
                                (lctl[1:0] == 2'b00 ? `TICKS_STOP_HALF :
                                 `TICKS_STOP_TWO))) begin
                                tx_state <= TX_IDLE;
                                tx_sub <= 6'd0;
                            end
                        end
                    end
                    default: tx_state <= TX_IDLE;
                endcase
            end
        end

        // Receiver samples mid-bit, checks only the first stop bit
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                rx_state <= RX_IDLE;
                rx_sh <= 8'h00;
                rx_bit <= 3'd0;
                rx_sub <= 6'd0;
                rx_par_bad <= 1'b0;
                rx_done <= 1'b0;
                rx_data <= 8'h00;
                rx_pe <= 1'b0;
                rx_fe <= 1'b0;
                rx_bi <= 1'b0;
            end else if (ce_i) begin
                rx_done <= 1'b0;
                if (tick) begin
                    rx_sub <= rx_sub + 6'd1;
                    case (rx_state)
                        RX_IDLE: begin
                            rx_sub <= 6'd0;
                            if (!rx_in) rx_state <= RX_START;
                        end
                        RX_START: begin
                            if (rx_sub == `TICKS_HALF) begin
                                rx_state <= rx_in ? RX_IDLE : RX_DATA;
                                rx_sub <= 6'd0;
                                rx_bit <= 3'd0;
                                rx_par_bad <= 1'b0;
                            end
                        end
                        RX_DATA: begin
                            if (rx_sub == `TICKS_BIT) begin
                                rx_sub <= 6'd0;
                                rx_bit <= rx_bit + 3'd1;
                                rx_sh <= {rx_in, rx_sh[7:1]};
                                if (rx_bit == {1'b1, lctl[1:0]}) begin
                                    rx_state <= lctl[3] ? RX_PARITY : RX_STOP;
                                end
                            end
                        end
                        RX_PARITY: begin
                            if (rx_sub == `TICKS_BIT) begin
                                rx_sub <= 6'd0;
                                rx_par_bad <= rx_in !=
                                    par_bit(rx_sh >> ~lctl[1:0], lctl);
                                rx_state <= RX_STOP;
                            end
                        end
                        RX_STOP: begin
                            if (rx_sub == `TICKS_BIT) begin
                                rx_state <= RX_IDLE;
                                rx_done <= 1'b1;
                                rx_data <= rx_sh >> ~lctl[1:0];
                                rx_pe <= rx_par_bad;
                                rx_fe <= ~rx_in;
                                rx_bi <= ~rx_in & (rx_sh == 8'h00);
                            end
                        end
                        default: rx_state <= RX_IDLE;
                    endcase
                end
            end
        end

        // Line status flags; a new event beats a clearing read
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                rx_hold <= 8'h00;
                dr <= 1'b0;
                {oe, pe, fe, bi} <= 4'h0;
            end else if (ce_i) begin
                if (lstat_rd) begin
                    {oe, pe, fe, bi} <= 4'h0;
                end
                if (rx_hold_rd) begin
                    dr <= 1'b0;
                end
                if (rx_done) begin
                    rx_hold <= rx_data;
                    dr <= 1'b1;
                    oe <= (dr & ~rx_hold_rd) | (oe & ~lstat_rd);
                    pe <= rx_pe | (pe & ~lstat_rd);
                    fe <= rx_fe | (fe & ~lstat_rd);
                    bi <= rx_bi | (bi & ~lstat_rd);
                end
            end
        end

        // Modem deltas cleared by reading the modem status
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                modem_prev <= 4'h0;
                delta <= 4'h0;
            end else if (ce_i) begin
                modem_prev <= modem_now;
                delta <= ((rd && wb_adr_i[5:0] == `OFS_MSTAT) ? 4'h0 : delta) |
                    {modem_now[3] ^ modem_prev[3],
                     modem_prev[2] & ~modem_now[2],
                     modem_now[1:0] ^ modem_prev[1:0]};
            end
        end

        // Sticky event bits, write one to clear, set wins
        assign evt = {|(modem_now ^ modem_prev), rx_done & (rx_pe | rx_fe |
                      rx_bi | dr), tx_load, rx_done};
        always_ff @(posedge mclk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                evt_stat <= 4'h0;
            end else if (ce_i) begin
                evt_stat <= evt | (evt_stat &
                    ~((wr && wb_adr_i[5:0] == `OFS_EVT_CLR) ?
                      wb_dat_i[3:0] : 4'h0));
            end
        end
        assign irq_port[g] = |(evt_stat & evt_en);

        always_comb begin
            if (ien[2] & (oe | pe | fe | bi)) iid = 3'b110;
            else if (ien[0] & dr) iid = 3'b100;
            else if (ien[1] & thre_int) iid = 3'b010;
            else if (ien[3] & |delta) iid = 3'b000;
            else iid = 3'b001;
        end
        assign ident = {{2{fifo_en}}, 3'b000, iid};
        assign lstat = {fifo_en & (oe | pe | fe | bi),
                        ~hold_full & tx_state == TX_IDLE, ~hold_full,
                        bi, fe, pe, oe, dr};

        always_comb begin
            case (wb_adr_i[5:0])
                `OFS_DATA: rd_mux = div_sel ? divisor[7:0] : rx_hold;
                `OFS_IEN: rd_mux = div_sel ? divisor[15:8] : {4'h0, ien};
                `OFS_IDENT: rd_mux = ident;
                `OFS_LCTL: rd_mux = lctl;
                `OFS_MCTL: rd_mux = {3'b000, mctl};
                `OFS_LSTAT: rd_mux = lstat;
                `OFS_MSTAT: rd_mux = {modem_now, delta};
                `OFS_SCRATCH: rd_mux = scratch;
                `OFS_EVT_STAT: rd_mux = {4'h0, evt_stat};
                `OFS_EVT_EN: rd_mux = {4'h0, evt_en};
                default: rd_mux = 8'h00;
            endcase
        end
        assign rd_val[g] = rd_mux;
    end
endmodule
`default_nettype wire

// ==== logic/dual_uart_defines.svh ====
// Offsets, field positions and reset values of the dual serial port
`ifndef DUAL_UART_DEFINES_SVH
`define DUAL_UART_DEFINES_SVH
`define FIRST_PORT_BASE 8'h00
`define SECOND_PORT_BASE 8'h40
`define OFS_DATA 6'h00
`define OFS_IEN 6'h04
`define OFS_IDENT 6'h08
`define OFS_LCTL 6'h0C
`define OFS_MCTL 6'h10
`define OFS_LSTAT 6'h14
`define OFS_MSTAT 6'h18
`define OFS_SCRATCH 6'h1C
`define OFS_EVT_STAT 6'h20
`define OFS_EVT_CLR 6'h24
`define OFS_EVT_EN 6'h28
`define LCTL_DIV_SEL 7
`define LCTL_BREAK 6
`define MCTL_LOOP 4
`define IDENT_RESET 8'h01
`define DIV_RESET 16'h0001
`define TICKS_BIT 6'd15
`define TICKS_HALF 6'd7
`define TICKS_STOP_ONE 6'd15
`define TICKS_STOP_HALF 6'd23
`define TICKS_STOP_TWO 6'd31
`endif

// ==== logic/dual_uart_pkg.sv ====
// Types shared by the dual serial port
package dual_uart_pkg;
    typedef enum logic [4:0] {
        TX_IDLE = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP = 5'b10000
    } tx_state_type;
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PARITY = 5'b01000,
        RX_STOP = 5'b10000
    } rx_state_type;
    typedef struct packed {
        logic dcd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } modem_in_type;
    typedef struct packed {
        logic dtr_n;
        logic rts_n;
    } modem_out_type;
endpackage

// ==== verif/dual_uart_properties.sv ====
// Bus and register-view checker for the dual serial port
`timescale 1ns/10ps
`default_nettype none
module dual_uart_properties (
    // System
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Interrupt
    input wire logic irq_o
);
    logic take;
    logic rd;
    logic wr;
    logic [1:0] div_sel;
    logic [1:0] fifo;
    logic [7:0] div_lo [2];
    wire logic p = wb_adr_i[6];
    wire logic [5:0] ofs = wb_adr_i[5:0];
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    assign rd = take && !wb_we_i;
    assign wr = take && wb_we_i && wb_sel_i[0] && !wb_adr_i[7];
    // Shadows follow software writes so reads can be predicted
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_sel <= 2'b00;
            fifo <= 2'b00;
            div_lo <= '{8'h01, 8'h01};
        end else if (wr) begin
            if (ofs == 6'h0C) div_sel[p] <= wb_dat_i[7];
            if (ofs == 6'h08) fifo[p] <= wb_dat_i[0];
            if (ofs == 6'h00 && div_sel[p]) div_lo[p] <= wb_dat_i[7:0];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    ack_after_take_a: assert property (take |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    ack_one_cycle_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    unmapped_zero_a: assert property (
        rd && wb_adr_i[7] |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data above byte lane not zero");
    legacy_iir_a: assert property (
        rd && !wb_adr_i[7] && ofs == 6'h08 && !fifo[p]
        |=> wb_dat_o[7:6] == 2'b00 && !wb_dat_o[3])
        else $error("fifo bits of identification set in legacy mode");
    legacy_lsr_a: assert property (
        rd && !wb_adr_i[7] && ofs == 6'h14 && !fifo[p] |=> !wb_dat_o[7])
        else $error("fifo error flag set in legacy mode");
    fifo_iir_a: assert property (
        rd && !wb_adr_i[7] && ofs == 6'h08 && fifo[p]
        |=> wb_dat_o[7:6] == 2'b11)
        else $error("fifo enabled bits missing from identification");
    div_read_a: assert property (
        rd && !wb_adr_i[7] && ofs == 6'h00 && div_sel[p]
        |=> wb_dat_o[7:0] == $past(div_lo[p]))
        else $error("divisor low byte read mismatch");
    cover property (wr && ofs == 6'h0C && wb_dat_i[7]);
    cover property (rd && ofs == 6'h08 && fifo[p]);
    cover property ($rose(irq_o));
endmodule
bind dual_uart dual_uart_properties i_props (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ==== verif/serial_peer.sv ====
// Far-end serial device facing both ports
`timescale 1ns/10ps
`default_nettype none
module serial_peer
    import dual_uart_pkg::*;
(
    // System
    input wire logic mclk_i,
    // Lines
    input wire logic [1:0] serial_out_i,
    output logic [1:0] serial_in_o,
    output modem_in_type [1:0] modem_o
);
    // Idle line marks; modem pins stay inactive
    initial begin
        serial_in_o = 2'b11;
        modem_o = '1;
    end
    task automatic send(input int p, input logic [7:0] d, input int clks);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_i);
            serial_in_o[p] <= f[i];
            repeat (clks - 1) @(posedge mclk_i);
        end
    endtask
    // Samples at mid-bit, so a short drift still reads clean
    task automatic receive(input int p, input int clks,
                           output logic [7:0] d);
        @(negedge serial_out_i[p]);
        repeat (clks / 2) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (clks) @(posedge mclk_i);
            d[i] = serial_out_i[p];
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the dual serial port
`timescale 1ns/10ps
`default_nettype none
module testbench
    import dual_uart_pkg::*;
;
    logic mclk_i, resetn_i, ce_i, cyc, stb, we, ack, irq;
    logic [7:0] adr, b, got;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [1:0] sin, sout;
    modem_in_type [1:0] min;
    modem_out_type [1:0] mout;
    int fails, total_checks, cycles;
    dual_uart i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .serial_in_i(sin), .serial_out_o(sout), .modem_i(min),
        .modem_o(mout), .irq_o(irq));
    serial_peer i_peer (.mclk_i(mclk_i), .serial_out_i(sout),
        .serial_in_o(sin), .modem_o(min));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic print_verdict();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run needs under a thousand cycles
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            print_verdict();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Called just after a rising edge; holds until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, d,
                       output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h0, d};
        // Only the watchdog ends a wait for ack
        do begin
            @(posedge mclk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic bus_write(input logic [7:0] a, d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic expect_read(input string what, input logic [7:0] a,
                               input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        check(what, r, e);
    endtask
    initial begin
        fails = 0;
        total_checks = 0;
        cycles = 0;
        resetn_i = 1'b0;
        ce_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        check("modem pins idle", {28'h0, mout}, 32'hF);
        for (int p = 0; p < 2; p++) begin
            b = 8'(p * 64);
            expect_read("ident reset", b + 8'h08, 32'h01);
            expect_read("line status reset", b + 8'h14, 32'h60);
            bus_write(b + 8'h1C, 8'h5A + 8'(p));
            bus_write(b + 8'h0C, 8'h83);
            bus_write(b + 8'h04, 8'hC3);
            expect_read("div high", b + 8'h04, 32'hC3);
            bus_write(b + 8'h04, 8'h00);
            // Port 0 runs at divisor 2, port 1 at divisor 1
            bus_write(b, 8'h02 - 8'(p));
            expect_read("div low", b, 32'h02 - 32'(p));
            bus_write(b + 8'h08, 8'h01);
            expect_read("ident fifo", b + 8'h08, 32'hC1);
            bus_write(b + 8'h0C, 8'h03);
            bus_write(b + 8'h04, 8'h05);
            expect_read("int enable", b + 8'h04, 32'h05);
            bus_write(b + 8'h08, 8'h00);
            expect_read("ident legacy", b + 8'h08, 32'h01);
        end
        expect_read("scratch 0", 8'h1C, 32'h5A);
        expect_read("scratch 1", 8'h5C, 32'h5B);
        bus_write(8'h9C, 8'hFF);
        expect_read("unmapped", 8'h9C, 32'h0);
        bus_write(8'h10, 8'h03);
        check("modem pins on", {28'h0, mout}, 32'hC);
        expect_read("modem status", 8'h18, 32'h0);
        fork
            i_peer.receive(0, 32, got);
            bus_write(8'h00, 8'hA5);
        join
        check("tx byte", {24'h0, got}, 32'hA5);
        bus_write(8'h68, 8'h01);
        i_peer.send(1, 8'h3C, 16);
        expect_read("line status ready", 8'h54, 32'h61);
        expect_read("ident rx", 8'h48, 32'h04);
        expect_read("rx byte", 8'h40, 32'h3C);
        check("irq set", {31'h0, irq}, 32'h1);
        bus_write(8'h68, 8'h00);
        check("irq masked", {31'h0, irq}, 32'h0);
        bus_write(8'h68, 8'h01);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        bus_write(8'h64, 8'h01);
        check("irq cleared", {31'h0, irq}, 32'h0);
        expect_read("events", 8'h60, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
